// ==== dcd_pkg.sv ====
// shared constants and types for the descriptor chained dma channel
package dcd_pkg;
    localparam int unsigned DESC_BYTES = 16;
    localparam logic [3:0] DESC_OFS_CFG = 4'h0;
    localparam logic [3:0] DESC_OFS_SRC = 4'h4;
    localparam logic [3:0] DESC_OFS_DST = 4'h8;
    localparam logic [3:0] DESC_OFS_LINK = 4'hc;
    // register byte offsets on the wishbone slave
    localparam logic [7:0] REG_TABLE_BASE = 8'h08;
    localparam logic [7:0] REG_CH_STRIDE = 8'h10;
    localparam logic [7:0] REG_CH_FIRST = 8'h40;
    localparam logic [3:0] REG_CH_CFG = 4'h0;
    localparam logic [3:0] REG_CH_XFER = 4'h4;
    localparam logic [3:0] REG_CH_STAT = 4'h8;
    localparam logic [3:0] REG_CH_TRIG = 4'hc;
    // channel config fields
    localparam int unsigned CFG_PERIPH_EN = 0;
    localparam int unsigned CFG_HWTRIG_EN = 1;
    localparam int unsigned CFG_TSEL_LSB = 8;
    // transfer config fields
    localparam int unsigned XF_VALID = 0;
    localparam int unsigned XF_RELOAD = 1;
    localparam int unsigned XF_SWTRIG = 2;
    localparam int unsigned XF_CLEAR_TRIGGER_ON_EXHAUST = 3;
    localparam int unsigned XF_SETINT = 4;
    localparam int unsigned XF_WIDTH_LSB = 8;
    localparam int unsigned XF_SRC_LSB = 12;
    localparam int unsigned XF_DST_LSB = 14;
    localparam int unsigned XF_CNT_LSB = 16;
    localparam int unsigned XF_CNT_W = 10;
    localparam int unsigned XF_BURST = 5;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef enum {
        DCD_IDLE, DCD_FETCH, DCD_RD, DCD_WR, DCD_DONE
    } dcd_state_t;
endpackage

// ==== dcd_step.sv ====
// address step and start address arithmetic for one side of a transfer
`timescale 1ns/1ps
module dcd_step (
    input wire logic [31:0] end_addr,
    input wire logic [1:0] step_sel,
    input wire logic [1:0] width_sel,
    input wire logic [9:0] count_left,
    output logic [31:0] addr
);
    logic [31:0] step_bytes;
    always_comb begin
        // step of 0 keeps a fixed address, else 1, 2 or 4 elements
        case (step_sel)
            2'h0: step_bytes = 32'h0;
            2'h1: step_bytes = 32'h1 << width_sel;
            2'h2: step_bytes = 32'h2 << width_sel;
            default: step_bytes = 32'h4 << width_sel;
        endcase
        // count_left holds remaining minus one, so the last access hits end_addr
        addr = end_addr - 32'(step_bytes * 32'(count_left));
    end
endmodule

// ==== dcd_bus.sv ====
// wishbone master for single word and sub word accesses
`timescale 1ns/1ps
module dcd_bus (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic we,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [1:0] width_sel,
    output logic done,
    output logic [31:0] rdata,
    output logic m_cyc,
    output logic m_stb,
    output logic m_we,
    output logic [31:0] m_adr,
    output logic [31:0] m_dat_o,
    output logic [3:0] m_sel,
    input wire logic [31:0] m_dat_i,
    input wire logic m_ack
);
    typedef struct packed {
        logic busy;
        logic we;
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic [31:0] rd;
        logic done;
    } dcd_bus_st_t;
    dcd_bus_st_t s_reg, s_next;
    logic [1:0] lane;
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        lane = addr[1:0];
        if (!s_reg.busy && req && !s_reg.done) begin
            s_next.busy = 1'b1;
            s_next.we = we;
            s_next.adr = {addr[31:2], 2'h0};
            case (width_sel)
                2'h0: s_next.sel = 4'h1 << lane;
                2'h1: s_next.sel = 4'h3 << {lane[1], 1'b0};
                default: s_next.sel = 4'hf;
            endcase
            s_next.dat = wdata << {lane, 3'h0};
        end else if (s_reg.busy && m_ack) begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
            s_next.rd = m_dat_i >> {s_reg.adr[1:0], 3'h0};
            if (s_reg.sel == 4'hf) begin
                s_next.rd = m_dat_i;
            end else if (s_reg.sel[1:0] == 2'h0) begin
                s_next.rd = m_dat_i >> (s_reg.sel[2] ? 16 : 24);
                if (s_reg.sel == 4'hc) begin
                    s_next.rd = m_dat_i >> 16;
                end
            end else if (s_reg.sel == 4'h2) begin
                s_next.rd = m_dat_i >> 8;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign rdata = s_reg.rd;
    assign done = s_reg.done;
    assign m_cyc = s_reg.busy;
    assign m_stb = s_reg.busy;
    assign m_we = s_reg.we;
    assign m_adr = s_reg.adr;
    assign m_dat_o = s_reg.dat;
    assign m_sel = s_reg.sel;
endmodule

// ==== dcd_top.sv ====
// multi channel descriptor chained dma with wishbone slave and master
// Operation
// - a channel starts from its request line or a selected trigger
// - triggered work may still be paced by the peripheral request
// - addresses may be fixed or incrementing on either side
// - every channel drives a trigger output usable by other channels
// - descriptor: transfer config (read on reload only), source end, destination end, link
// - start address is end minus count times step
// - end address names the last element; accesses derive from it
// - exhausted reloading descriptor fetches new one at link address
// - reloaded word 0 replaces the transfer configuration
// - reloading repeats while each new configuration asks for reload
// - without reload the channel does its transfers then stops
// - after exhaustion without reload, requests ignored until reconfigured
// - exhausting in a chain loads the link and raises interrupt
// - one request starts a transfer, burst, descriptor or chain
// - linked descriptors are read from memory when reloaded
// - a writable table base locates initial descriptors
// - clear trigger option drops the trigger on exhaustion
`timescale 1ns/1ps
module dcd_top #(
    parameter int unsigned NCH = 4,
    parameter int unsigned NTRIG = 8,
    parameter int unsigned BURST = 4
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [31:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_STB_I,
    input wire logic WB_CYC_I,
    output logic WB_ACK_O,
    output logic M_CYC_O,
    output logic M_STB_O,
    output logic M_WE_O,
    output logic [31:0] M_ADR_O,
    output logic [31:0] M_DAT_O,
    output logic [3:0] M_SEL_O,
    input wire logic [31:0] M_DAT_I,
    input wire logic M_ACK_I,
    input wire logic [NCH-1:0] PERIPH_REQ,
    input wire logic [NTRIG-1:0] TRIG_IN,
    output logic [NCH-1:0] TRIG_OUT,
    output logic [NCH-1:0] XFER_IRQ
);
    localparam int unsigned CW = (NCH > 1) ? $clog2(NCH) : 1;
    typedef struct packed {
        dcd_pkg::dcd_state_t st;
        logic [CW-1:0] ch;
        logic [1:0] widx;
        logic [31:0] data;
        logic [2:0] burst;
        logic bus_req;
        logic ack;
        logic [31:0] rdat;
        logic [31:0] descriptor_table_base;
        logic [NCH-1:0][31:0] chcfg;
        logic [NCH-1:0][31:0] transfer_config_reg;
        logic [NCH-1:0][31:0] src_end;
        logic [NCH-1:0][31:0] dst_end;
        logic [NCH-1:0][31:0] link;
        logic [NCH-1:0][9:0] transfer_count;
        logic [NCH-1:0] trig;
        logic [NCH-1:0] active;
        logic [NCH-1:0] fresh;
        logic [NCH-1:0] trig_out;
        logic [NCH-1:0] irq;
        logic [NCH-1:0] req_s1;
        logic [NCH-1:0] req_s2;
        logic [NTRIG-1:0] tr_s1;
        logic [NTRIG-1:0] tr_s2;
        logic [NTRIG-1:0] tr_s3;
    } dcd_st_t;
    dcd_st_t s_reg, s_next;
    logic bus_done;
    logic [31:0] bus_rdata;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [31:0] cur_xf;
    logic [31:0] bus_addr;
    logic [NCH-1:0] ready;
    logic [NTRIG-1:0] tr_rise;
    logic [NCH-1:0] ch_ok;
    logic [7:0] woff;
    logic [CW-1:0] wch;
    logic wsel;
    logic [CW-1:0] pick;
    logic any;
    assign cur_xf = s_reg.transfer_config_reg[s_reg.ch];
    assign tr_rise = s_reg.tr_s2 & ~s_reg.tr_s3;
    dcd_step u_src (
        .end_addr(s_reg.src_end[s_reg.ch]),
        .step_sel(cur_xf[dcd_pkg::XF_SRC_LSB +: 2]),
        .width_sel(cur_xf[dcd_pkg::XF_WIDTH_LSB +: 2]),
        .count_left(s_reg.transfer_count[s_reg.ch]),
        .addr(src_addr)
    );
    dcd_step u_dst (
        .end_addr(s_reg.dst_end[s_reg.ch]),
        .step_sel(cur_xf[dcd_pkg::XF_DST_LSB +: 2]),
        .width_sel(cur_xf[dcd_pkg::XF_WIDTH_LSB +: 2]),
        .count_left(s_reg.transfer_count[s_reg.ch]),
        .addr(dst_addr)
    );
    always_comb begin
        case (s_reg.st)
            dcd_pkg::DCD_FETCH: bus_addr = s_reg.fresh[s_reg.ch]
                ? s_reg.descriptor_table_base + 32'(s_reg.ch) * dcd_pkg::DESC_BYTES
                    + 32'({s_reg.widx, 2'h0})
                : s_reg.link[s_reg.ch] + 32'({s_reg.widx, 2'h0});
            dcd_pkg::DCD_WR: bus_addr = dst_addr;
            default: bus_addr = src_addr;
        endcase
    end
    dcd_bus u_bus (
        .clk(CLK),
        .rst_n(RST_N),
        .req(s_reg.bus_req),
        .we(s_reg.st == dcd_pkg::DCD_WR),
        .addr(bus_addr),
        .wdata(s_reg.data),
        .width_sel((s_reg.st == dcd_pkg::DCD_FETCH) ? 2'h2 : cur_xf[dcd_pkg::XF_WIDTH_LSB +: 2]),
        .done(bus_done),
        .rdata(bus_rdata),
        .m_cyc(M_CYC_O),
        .m_stb(M_STB_O),
        .m_we(M_WE_O),
        .m_adr(M_ADR_O),
        .m_dat_o(M_DAT_O),
        .m_sel(M_SEL_O),
        .m_dat_i(M_DAT_I),
        .m_ack(M_ACK_I)
    );
    // per channel readiness: trigger held if hardware triggering enabled, and request if pacing selected
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign ch_ok[g] = s_reg.active[g] && s_reg.transfer_config_reg[g][dcd_pkg::XF_VALID];
        assign ready[g] = ch_ok[g] && (s_reg.trig[g] || !s_reg.chcfg[g][dcd_pkg::CFG_HWTRIG_EN])
            && (s_reg.req_s2[g] || !s_reg.chcfg[g][dcd_pkg::CFG_PERIPH_EN]);
    end
    always_comb begin
        pick = '0;
        any = 1'b0;
        // lowest channel wins; a fixed order keeps the arbiter small
        for (int i = NCH - 1; i >= 0; i--) begin
            if (ready[i]) begin
                pick = CW'(i);
                any = 1'b1;
            end
        end
    end
    always_comb begin
        s_next = s_reg;
        s_next.ack = 1'b0;
        s_next.bus_req = 1'b0;
        s_next.trig_out = '0;
        s_next.irq = '0;
        s_next.req_s1 = PERIPH_REQ;
        s_next.req_s2 = s_reg.req_s1;
        s_next.tr_s1 = TRIG_IN;
        s_next.tr_s2 = s_reg.tr_s1;
        s_next.tr_s3 = s_reg.tr_s2;
        woff = WB_ADR_I[7:0];
        wch = CW'((woff - dcd_pkg::REG_CH_FIRST) >> 4);
        wsel = (woff >= dcd_pkg::REG_CH_FIRST)
            && (woff < dcd_pkg::REG_CH_FIRST + 8'(NCH) * dcd_pkg::REG_CH_STRIDE);
        if (WB_CYC_I && WB_STB_I && !s_reg.ack) begin
            s_next.ack = 1'b1;
            s_next.rdat = '0;
            if (woff == dcd_pkg::REG_TABLE_BASE) begin
                s_next.rdat = s_reg.descriptor_table_base;
                if (WB_WE_I) begin
                    s_next.descriptor_table_base = {WB_DAT_I[31:4], 4'h0};
                end
            end else if (wsel) begin
                case (woff[3:0])
                    dcd_pkg::REG_CH_CFG: begin
                        s_next.rdat = s_reg.chcfg[wch];
                        if (WB_WE_I) begin
                            s_next.chcfg[wch] = WB_DAT_I;
                        end
                    end
                    dcd_pkg::REG_CH_XFER: begin
                        s_next.rdat = s_reg.transfer_config_reg[wch];
                        if (WB_WE_I && !(s_reg.st != dcd_pkg::DCD_IDLE && s_reg.ch == wch)) begin
                            // a write rearms the channel from its initial descriptor
                            s_next.transfer_config_reg[wch] = WB_DAT_I;
                            s_next.active[wch] = 1'b0;
                            s_next.fresh[wch] = 1'b1;
                            s_next.trig[wch] = WB_DAT_I[dcd_pkg::XF_SWTRIG];
                        end
                    end
                    dcd_pkg::REG_CH_STAT: s_next.rdat = {20'h0, s_reg.transfer_count[wch],
                        s_reg.trig[wch], s_reg.active[wch]};
                    default: begin
                        s_next.rdat = {31'h0, s_reg.trig[wch]};
                        if (WB_WE_I && WB_DAT_I[0]) begin
                            s_next.trig[wch] = 1'b1;
                        end
                    end
                endcase
            end
        end
        case (s_reg.st)
            dcd_pkg::DCD_IDLE: begin
                for (int i = 0; i < NCH; i++) begin
                    // a valid config not yet loaded pulls the initial descriptor
                    if (!s_reg.active[i] && s_reg.fresh[i]
                        && s_reg.transfer_config_reg[i][dcd_pkg::XF_VALID]
                        && s_next.st == dcd_pkg::DCD_IDLE) begin
                        s_next.st = dcd_pkg::DCD_FETCH;
                        s_next.ch = CW'(i);
                        s_next.widx = 2'h1;
                        s_next.bus_req = 1'b1;
                    end
                end
                if (s_next.st == dcd_pkg::DCD_IDLE && any) begin
                    s_next.st = dcd_pkg::DCD_RD;
                    s_next.ch = pick;
                    s_next.burst = 3'h0;
                    s_next.bus_req = 1'b1;
                end
            end
            dcd_pkg::DCD_FETCH: if (bus_done) begin
                case ({s_reg.widx, 2'h0})
                    dcd_pkg::DESC_OFS_CFG: s_next.transfer_config_reg[s_reg.ch] = bus_rdata;
                    dcd_pkg::DESC_OFS_SRC: s_next.src_end[s_reg.ch] = bus_rdata;
                    dcd_pkg::DESC_OFS_DST: s_next.dst_end[s_reg.ch] = bus_rdata;
                    default: s_next.link[s_reg.ch] = bus_rdata;
                endcase
                if (s_reg.widx == 2'h3) begin
                    s_next.st = dcd_pkg::DCD_IDLE;
                    s_next.fresh[s_reg.ch] = 1'b0;
                    s_next.active[s_reg.ch] = 1'b1;
                    if (s_reg.fresh[s_reg.ch]) begin
                        s_next.transfer_count[s_reg.ch] = cur_xf[dcd_pkg::XF_CNT_LSB +: 10];
                    end else begin
                        s_next.transfer_count[s_reg.ch] =
                            s_next.transfer_config_reg[s_reg.ch][dcd_pkg::XF_CNT_LSB +: 10];
                    end
                end else begin
                    s_next.widx = s_reg.widx + 2'h1;
                    s_next.bus_req = 1'b1;
                end
            end
            dcd_pkg::DCD_RD: if (bus_done) begin
                s_next.data = bus_rdata;
                s_next.st = dcd_pkg::DCD_WR;
                s_next.bus_req = 1'b1;
            end
            dcd_pkg::DCD_WR: if (bus_done) begin
                s_next.st = dcd_pkg::DCD_IDLE;
                s_next.burst = s_reg.burst + 3'h1;
                if (s_reg.transfer_count[s_reg.ch] == '0) begin
                    s_next.st = dcd_pkg::DCD_DONE;
                end else begin
                    s_next.transfer_count[s_reg.ch] = s_reg.transfer_count[s_reg.ch] - 10'h1;
                    // burst option keeps going on one trigger; else pace per request
                    if (cur_xf[dcd_pkg::XF_BURST] && 32'(s_next.burst) < BURST
                        && (s_reg.req_s2[s_reg.ch] || !s_reg.chcfg[s_reg.ch][dcd_pkg::CFG_PERIPH_EN])) begin
                        s_next.st = dcd_pkg::DCD_RD;
                        s_next.bus_req = 1'b1;
                    end
                end
            end
            dcd_pkg::DCD_DONE: begin
                s_next.st = dcd_pkg::DCD_IDLE;
                s_next.trig_out[s_reg.ch] = 1'b1;
                s_next.irq[s_reg.ch] = cur_xf[dcd_pkg::XF_SETINT] | cur_xf[dcd_pkg::XF_RELOAD];
                if (cur_xf[dcd_pkg::XF_CLEAR_TRIGGER_ON_EXHAUST]) begin
                    s_next.trig[s_reg.ch] = 1'b0;
                end
                if (cur_xf[dcd_pkg::XF_RELOAD]) begin
                    s_next.st = dcd_pkg::DCD_FETCH;
                    s_next.widx = 2'h0;
                    s_next.bus_req = 1'b1;
                end else begin
                    // parked until software writes the transfer config again
                    s_next.active[s_reg.ch] = 1'b0;
                    s_next.transfer_config_reg[s_reg.ch][dcd_pkg::XF_VALID] = 1'b0;
                end
            end
            default: s_next.st = dcd_pkg::DCD_IDLE;
        endcase
        // placed last: a new trigger edge wins over a clear in the same cycle
        for (int i = 0; i < NCH; i++) begin
            if (s_reg.chcfg[i][dcd_pkg::CFG_HWTRIG_EN]
                && tr_rise[s_reg.chcfg[i][dcd_pkg::CFG_TSEL_LSB +: 3]]) begin
                s_next.trig[i] = 1'b1;
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s_reg <= '0;
            s_reg.st <= dcd_pkg::DCD_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end
    assign WB_ACK_O = s_reg.ack;
    assign WB_DAT_O = s_reg.rdat;
    assign TRIG_OUT = s_reg.trig_out;
    assign XFER_IRQ = s_reg.irq;
endmodule

// ==== dcd_mem.sv ====
// wishbone memory model behind the dma master port
`timescale 1ns/1ps
module dcd_mem (
    input wire logic clk,
    input wire logic cyc,
    input wire logic stb,
    input wire logic we,
    input wire logic [31:0] adr,
    input wire logic [31:0] dat_w,
    input wire logic [3:0] sel,
    input wire logic [3:0] lat,
    output logic [31:0] dat_r,
    output logic ack
);
    logic [31:0] mem [0:255];
    logic [3:0] wait_cnt = 4'h0;
    initial begin
        ack = 1'b0;
        dat_r = 32'h0;
        for (int i = 0; i < 256; i++) mem[i] = 32'h0;
    end
    // lat stalls let the master be seen against a slow and a prompt memory
    always @(posedge clk) begin
        if (cyc && stb && !ack && wait_cnt >= lat) begin
            ack <= 1'b1;
            dat_r <= mem[adr[9:2]];
            wait_cnt <= 4'h0;
            for (int b = 0; b < 4; b++) begin
                if (we && sel[b]) mem[adr[9:2]][8*b +: 8] <= dat_w[8*b +: 8];
            end
        end else begin
            ack <= 1'b0;
            // toggles so stale read data never passes for an answer
            dat_r <= ~dat_r;
            if (cyc && stb && !ack) wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// ==== dcd_top_sva.sv ====
// concurrent checks on the ports of the dma top
`timescale 1ns/1ps
module dcd_chk #(
    parameter int unsigned NCH = 4
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic M_CYC_O,
    input wire logic M_STB_O,
    input wire logic M_WE_O,
    input wire logic [31:0] M_ADR_O,
    input wire logic M_ACK_I,
    input wire logic [NCH-1:0] TRIG_OUT,
    input wire logic [NCH-1:0] XFER_IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_wb_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_m_wait;
        M_STB_O && !M_ACK_I;
    endsequence
    sequence s_m_done;
        M_STB_O && M_ACK_I;
    endsequence
    chk_wb_ack_timing: assert property (s_wb_req |=> WB_ACK_O)
        else $error("slave ack not one cycle after request");
    chk_wb_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("slave ack without request");
    chk_wb_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("slave ack longer than one cycle");
    chk_master_hold: assert property (s_m_wait |=> M_STB_O && M_CYC_O && $stable(M_ADR_O)
        && $stable(M_WE_O)) else $error("master request changed before ack");
    chk_master_idle: assert property (s_m_done |=> !M_STB_O && !M_CYC_O)
        else $error("master request not dropped after ack");
    chk_master_align: assert property (M_STB_O |-> M_ADR_O[1:0] == 2'h0)
        else $error("master address not word aligned");
    chk_trig_pulse: assert property (TRIG_OUT != '0 |=> (TRIG_OUT & $past(TRIG_OUT)) == '0)
        else $error("trigger output longer than one cycle");
    chk_irq_pulse: assert property (XFER_IRQ != '0 |=> (XFER_IRQ & $past(XFER_IRQ)) == '0)
        else $error("transfer interrupt longer than one cycle");
    chk_irq_at_exhaust: assert property (XFER_IRQ != '0 |-> (XFER_IRQ & ~TRIG_OUT) == '0)
        else $error("interrupt without exhaustion");
endmodule
bind dcd_top dcd_chk #(.NCH(NCH)) u_dcd_chk (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .M_CYC_O(M_CYC_O), .M_STB_O(M_STB_O),
    .M_WE_O(M_WE_O), .M_ADR_O(M_ADR_O), .M_ACK_I(M_ACK_I), .TRIG_OUT(TRIG_OUT),
    .XFER_IRQ(XFER_IRQ));

// ==== test_descriptor_chained_dma_channel.sv ====
// self checking bench for the descriptor chained dma top
`timescale 1ns/1ps
module test_descriptor_chained_dma_channel;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [31:0] wb_adr = 32'h0, wb_dat = 32'h0, wb_dat_o, wb_q, m_adr, m_dat_o, m_dat_i;
    logic wb_we = 1'b0, wb_stb = 1'b0, wb_cyc = 1'b0, wb_ack, m_cyc, m_stb, m_we, m_ack;
    logic [3:0] m_sel, trig_out, irq, lat = 4'h0, req = 4'h0, ext = 4'h0;
    int fails = 0, n_compared = 0, n_acc = 0, cyc_cnt = 0, k;
    int n_trig [4] = '{0, 0, 0, 0};
    int n_irq [4] = '{0, 0, 0, 0};
    always #5 CLK = ~CLK;
    dcd_top #(.NCH(4), .NTRIG(8), .BURST(4)) u_dcd_top (.CLK(CLK), .RST_N(RST_N),
        .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_dat_o), .WB_WE_I(wb_we),
        .WB_SEL_I(4'hf), .WB_STB_I(wb_stb), .WB_CYC_I(wb_cyc), .WB_ACK_O(wb_ack),
        .M_CYC_O(m_cyc), .M_STB_O(m_stb), .M_WE_O(m_we), .M_ADR_O(m_adr), .M_DAT_O(m_dat_o),
        .M_SEL_O(m_sel), .M_DAT_I(m_dat_i), .M_ACK_I(m_ack), .PERIPH_REQ(req),
        .TRIG_IN({trig_out, ext}), .TRIG_OUT(trig_out), .XFER_IRQ(irq));
    dcd_mem u_dcd_mem (.clk(CLK), .cyc(m_cyc), .stb(m_stb), .we(m_we), .adr(m_adr),
        .dat_w(m_dat_o), .sel(m_sel), .lat(lat), .dat_r(m_dat_i), .ack(m_ack));
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge CLK) begin
        for (int i = 0; i < 4; i++) begin
            n_trig[i] += int'(trig_out[i]);
            n_irq[i] += int'(irq[i]);
        end
        if (m_cyc && m_stb && m_ack) n_acc++;
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge CLK);
        wb_adr <= {24'h0, a};
        wb_we <= w;
        wb_dat <= d;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        do begin
            @(posedge CLK);
            t++;
        end while (wb_ack !== 1'b1 && t < 50);
        if (t >= 50) fails++;
        wb_q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic wait_trig(input int ch, input int n);
        int t;
        t = 0;
        while (n_trig[ch] < n && t < 3000) begin
            @(posedge CLK);
            t++;
        end
        if (t >= 3000) fails++;
    endtask
    task automatic mw(input logic [31:0] a, input logic [31:0] d);
        u_dcd_mem.mem[a[9:2]] = d;
    endtask
    function automatic logic [31:0] mr(input logic [31:0] a);
        return u_dcd_mem.mem[a[9:2]];
    endfunction
    initial begin
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        wb(8'h08, 1'b1, 32'h0000_010c);
        wb(8'h08, 1'b0, 32'h0);
        chk(wb_q, 32'h0000_0100);
        wb(8'h04, 1'b0, 32'h0);
        chk(wb_q, 32'h0);
        wb(8'h44, 1'b0, 32'h0);
        chk(wb_q, 32'h0);
        $display("registers test done");
        for (int i = 0; i < 4; i++) mw(32'h210 + 32'(4 * i), 32'ha5a5_0000 + 32'(i));
        mw(32'h104, 32'h0000_021c);
        mw(32'h108, 32'h0000_031c);
        mw(32'h10c, 32'h0000_03f0);
        wb(8'h40, 1'b1, 32'h0);
        wb(8'h44, 1'b1, 32'h0003_5211);
        wait_trig(0, 1);
        for (int i = 0; i < 4; i++) chk(mr(32'h310 + 32'(4 * i)), 32'ha5a5_0000 + 32'(i));
        chk(32'(n_irq[0]), 32'h1);
        k = n_acc;
        wb(8'h4c, 1'b1, 32'h1);
        repeat (40) @(posedge CLK);
        chk(32'(n_acc), 32'(k));
        $display("single buffer test done");
        mw(32'h200, 32'hc3c3_0001);
        mw(32'h114, 32'h0000_0200);
        mw(32'h118, 32'h0000_0304);
        mw(32'h11c, 32'h0000_0140);
        mw(32'h140, 32'h0000_4211);
        mw(32'h144, 32'h0000_0200);
        mw(32'h148, 32'h0000_03f0);
        lat <= 4'h3;
        wb(8'h50, 1'b1, 32'h1);
        wb(8'h54, 1'b1, 32'h0001_4213);
        repeat (30) @(posedge CLK);
        chk(mr(32'h300), 32'h0);
        mw(32'h148, 32'h0000_0308);
        req[1] <= 1'b1;
        wait_trig(1, 2);
        req[1] <= 1'b0;
        for (int i = 0; i < 3; i++) chk(mr(32'h300 + 32'(4 * i)), 32'hc3c3_0001);
        chk(32'(n_irq[1]), 32'h2);
        $display("linked paced test done");
        mw(32'h204, 32'h5a5a_0002);
        mw(32'h124, 32'h0000_0204);
        mw(32'h128, 32'h0000_0380);
        mw(32'h134, 32'h0000_0380);
        mw(32'h138, 32'h0000_0384);
        lat <= 4'h1;
        wb(8'h60, 1'b1, 32'h0000_0002);
        wb(8'h70, 1'b1, 32'h0000_0602);
        wb(8'h64, 1'b1, 32'h0000_5209);
        wb(8'h74, 1'b1, 32'h0000_5201);
        repeat (30) @(posedge CLK);
        chk(mr(32'h380), 32'h0);
        ext[0] <= 1'b1;
        repeat (3) @(posedge CLK);
        ext[0] <= 1'b0;
        wait_trig(3, 1);
        chk(mr(32'h384), 32'h5a5a_0002);
        wb(8'h68, 1'b0, 32'h0);
        chk({31'h0, wb_q[1]}, 32'h0);
        $display("trigger chain test done");
        // halfword lanes: two aligned halves packed into one destination word
        mw(32'h220, 32'h1234_abcd);
        mw(32'h104, 32'h0000_0222);
        mw(32'h108, 32'h0000_0392);
        wb(8'h44, 1'b1, 32'h0001_5101);
        wait_trig(0, 2);
        chk(mr(32'h390), 32'h1234_abcd);
        $display("halfword test done");
        results();
    end
endmodule
